/* rtl/g2lt_pkg.sv */
// Purpose: Constants and carriers for the Gen2 link timing register bank
// Assumes: 8-bit registers, 5-bit register address
// Notes:   All presets and decodes live here
package g2lt_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [4:0] ADR_TX_SHAPE  = 5'h02;
  localparam logic [4:0] ADR_RX_LINK   = 5'h03;
  localparam logic [4:0] ADR_CAL_LOW   = 5'h04;
  localparam logic [4:0] ADR_CAL_HIGH  = 5'h05;
  localparam logic [7:0] RST_TX_SHAPE  = 8'hf0;
  localparam logic [7:0] RST_RX_LINK   = 8'h60;
  localparam logic [7:0] RST_CAL_LOW   = 8'h35;
  localparam logic [7:0] RST_CAL_HIGH  = 8'h05;
  // ----------------------------------------
  // Direct command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_QUERY     = 8'h98;
  localparam logic [7:0] CMD_TX_CRC    = 8'h90;
  localparam logic [7:0] CMD_TX_NOCRC  = 8'h91;
  // ----------------------------------------
  // Timing units (ns) and fractions (1/100)
  // ----------------------------------------
  localparam logic [15:0] TARI_0_NS    = 16'h186a; // 6250
  localparam logic [15:0] TARI_1_NS    = 16'h30d4; // 12500
  localparam logic [15:0] TARI_2_NS    = 16'h61a8; // 25000
  localparam logic [7:0]  PW_FRAC [4]  = '{8'h1b, 8'h23, 8'h2c, 8'h32};
  localparam logic [7:0]  ONE_FRAC [4] = '{8'h96, 8'ha6, 8'hb7, 8'hc8};
  localparam logic [7:0]  FRAC_DIV     = 8'h64;
  localparam logic [6:0]  PILOT_BASE   = 7'h50;
  // ----------------------------------------
  // Link frequency codes and values (kHz)
  // ----------------------------------------
  localparam logic [3:0]  LF_40_SEL    = 4'h0;
  localparam logic [3:0]  LF_160_SEL   = 4'h6;
  localparam logic [3:0]  LF_256_SEL   = 4'h9;
  localparam logic [3:0]  LF_320_SEL   = 4'hc;
  localparam logic [3:0]  LF_640_SEL   = 4'hf;
  localparam logic [9:0]  LF_40_KHZ    = 10'h028;
  localparam logic [9:0]  LF_160_KHZ   = 10'h0a0;
  localparam logic [9:0]  LF_256_KHZ   = 10'h100;
  localparam logic [9:0]  LF_320_KHZ   = 10'h140;
  localparam logic [9:0]  LF_640_KHZ   = 10'h280;
  localparam logic [1:0]  COD_M4       = 2'h2;
  localparam logic [1:0]  COD_M8       = 2'h3;

  typedef struct packed {
    logic [1:0] pulse_width_sel;
    logic [1:0] data1_length_sel;
    logic       crc5;
    logic       force_calibration_period;
    logic [1:0] session;
  } g2lt_tx_t;

  typedef struct packed {
    logic [3:0] link_freq_sel;
    logic [1:0] pilot_interval_shorten;
    logic       long_preamble;
    logic       spare;
  } g2lt_rx_t;

  typedef struct packed {
    logic       gain_increase;
    logic       mix_low_supply;
    logic       io_low_voltage;
    logic       open_drain_outputs;
    logic [3:0] cal_high;
  } g2lt_hi_t;

  typedef struct packed {
    logic clk;
    logic ana_a;
    logic ana_b;
  } g2lt_pin3_t;
endpackage

/* rtl/g2lt_regs.sv */
// Purpose: Gen2 link timing configuration registers and their decodes
// Assumes: Host access logic on sys_clk_i; chip enable arrives from a pin
// Notes:   Everything derived is registered one cycle after its source; Tari-scaled timings take two
// How it works
// - Pulse width and data-1 length come from two 2-bit Tari fractions.
// - Query command 98 always requests the calibration period.
// - Force bit adds the calibration period to commands 90 and 91.
// - Session bits 1:0 of the transmit options feed direct commands.
// - Four-bit code picks link frequency 40, 160, 256, 320 or 640 kHz.
// - Two-bit field shortens pilot interval to a half, quarter or eighth.
// - Applied pilot interval is one of 80, 40, 20 or 10 periods.
// - Short preamble only honoured with Miller 4 or Miller 8 coding.
// - Calibration count is 12 bits of 0.1 us: low byte plus nibble.
// - Reset or chip enable low presets calibration low byte to 35 hex.
// - Gain direction bit: cleared decreases gain steps, set increases.
// - Mixer low-supply bit selects the 3.7 V mixer supply mode.
// - Low interface voltage bit lowers logic output resistance.
// - Open-drain bit makes clock and analog-out pins open-drain.
// - Reset or chip enable low presets transmit options to f0 hex.
// - Reset or chip enable low presets receive options to 60 hex.
// - Reset or chip enable low presets calibration high register to 05.
// - Tari unit follows protocol code: 6.25, 12.5 or 25 us.
`timescale 1ns/100ps
module g2lt_regs
#(
  parameter int ADDR_W = 5
)
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              nrst_i,
  // Chip enable pin
  input  wire logic              chip_en_i,
  // Host register port
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  output logic      [7:0]        rdata_o,
  output logic                   rvalid_o,
  // Protocol control from register 01
  input  wire logic [1:0]        tari_sel_i,
  input  wire logic [1:0]        rx_cod_i,
  // Direct commands
  input  wire logic              cmd_valid_i,
  input  wire logic [7:0]        cmd_code_i,
  output logic                   cal_insert_o,
  output logic [1:0]             session_o,
  // Transmit timing
  output logic [15:0]            pulse_width_ns_o,
  output logic [15:0]            data1_length_ns_o,
  output logic                   crc5_o,
  // Receive timing
  output logic [3:0]             link_freq_sel_o,
  output logic [9:0]             link_freq_khz_o,
  output logic [6:0]             pilot_periods_o,
  output logic                   long_preamble_o,
  output logic [11:0]            cal_steps_o,
  // Analog and pad controls
  output logic                   gain_increase_o,
  output logic                   mix_low_supply_o,
  output logic                   io_low_drive_o,
  // Pads: system clock out, analog out a and b
  input  wire g2lt_pkg::g2lt_pin3_t pin_data_i,
  output g2lt_pkg::g2lt_pin3_t   pin_out_o,
  output g2lt_pkg::g2lt_pin3_t   pin_oe_o
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // The decode compares bytes, so a wider address would alias onto the map
  if ((ADDR_W < 3) || (ADDR_W > 8))
  begin
    $error("ADDR_W must lie between 3 and 8");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [1:0]          en_sync;
    g2lt_pkg::g2lt_tx_t  tx;
    g2lt_pkg::g2lt_rx_t  rx;
    logic [7:0]          cal_low;
    g2lt_pkg::g2lt_hi_t  hi;
    logic [7:0]          rdata;
    logic                rvalid;
    logic                cal_insert;
    logic [1:0]          session;
    logic [15:0]         tari_ns;
    logic [15:0]         pw_ns;
    logic [15:0]         one_ns;
    logic                crc5;
    logic [3:0]          lf_sel;
    logic [9:0]          lf_khz;
    logic [6:0]          pilot;
    logic                long_pre;
    logic [11:0]         cal_steps;
    logic                gain_inc;
    logic                mix_low;
    logic                io_low;
    g2lt_pkg::g2lt_pin3_t pin_out;
    g2lt_pkg::g2lt_pin3_t pin_oe;
  } g2lt_state_t;

  g2lt_state_t st_r;
  g2lt_state_t st_nxt;
  logic        en_s;
  logic [7:0]  waddr;
  logic [31:0] pw_prod;
  logic [31:0] one_prod;

  // ----------------------------------------
  // Synchronised enable and byte-wide address
  // ----------------------------------------
  assign en_s  = st_r.en_sync[1];
  assign waddr = 8'(addr_i);

  // ----------------------------------------
  // Tari scaling
  // ----------------------------------------
  // Scaling is from the previous Tari so a protocol change settles in two cycles
  assign pw_prod  = 32'(st_r.tari_ns) * 32'(g2lt_pkg::PW_FRAC[st_r.tx.pulse_width_sel])
                    / 32'(g2lt_pkg::FRAC_DIV);
  assign one_prod = 32'(st_r.tari_ns) * 32'(g2lt_pkg::ONE_FRAC[st_r.tx.data1_length_sel])
                    / 32'(g2lt_pkg::FRAC_DIV);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt            = st_r;
    st_nxt.en_sync    = {st_r.en_sync[0], chip_en_i};
    st_nxt.rvalid     = 1'b0;
    st_nxt.cal_insert = 1'b0;

    // ----------------------------------------
    // Presets and host writes
    // ----------------------------------------
    // Chip enable low holds the presets; host writes are dropped meanwhile
    if (!en_s)
    begin
      st_nxt.tx      = g2lt_pkg::RST_TX_SHAPE;
      st_nxt.rx      = g2lt_pkg::RST_RX_LINK;
      st_nxt.cal_low = g2lt_pkg::RST_CAL_LOW;
      st_nxt.hi      = g2lt_pkg::RST_CAL_HIGH;
    end
    else if (wr_i)
    begin
      if (waddr == 8'(g2lt_pkg::ADR_TX_SHAPE))
        st_nxt.tx = wdata_i;
      if (waddr == 8'(g2lt_pkg::ADR_RX_LINK))
        st_nxt.rx = wdata_i;
      if (waddr == 8'(g2lt_pkg::ADR_CAL_LOW))
        st_nxt.cal_low = wdata_i;
      if (waddr == 8'(g2lt_pkg::ADR_CAL_HIGH))
        st_nxt.hi = wdata_i;
    end

    // ----------------------------------------
    // Host reads
    // ----------------------------------------
    // Reads return the stored value one cycle later; unmapped reads zero
    if (rd_i)
    begin
      st_nxt.rvalid = 1'b1;
      if (waddr == 8'(g2lt_pkg::ADR_TX_SHAPE))
        st_nxt.rdata = st_r.tx;
      else if (waddr == 8'(g2lt_pkg::ADR_RX_LINK))
        st_nxt.rdata = st_r.rx;
      else if (waddr == 8'(g2lt_pkg::ADR_CAL_LOW))
        st_nxt.rdata = st_r.cal_low;
      else if (waddr == 8'(g2lt_pkg::ADR_CAL_HIGH))
        st_nxt.rdata = st_r.hi;
      else
        st_nxt.rdata = 8'h00;
    end

    // ----------------------------------------
    // Direct commands
    // ----------------------------------------
    // Calibration period insertion per direct command
    if (cmd_valid_i)
    begin
      if (cmd_code_i == g2lt_pkg::CMD_QUERY)
        st_nxt.cal_insert = 1'b1;
      else if ((cmd_code_i == g2lt_pkg::CMD_TX_CRC)
               || (cmd_code_i == g2lt_pkg::CMD_TX_NOCRC))
        st_nxt.cal_insert = st_r.tx.force_calibration_period;
    end
    st_nxt.session = st_r.tx.session;

    // ----------------------------------------
    // Tari unit and transmit timings
    // ----------------------------------------
    // Tari unit
    unique case (tari_sel_i)
      2'h0:    st_nxt.tari_ns = g2lt_pkg::TARI_0_NS;
      2'h1:    st_nxt.tari_ns = g2lt_pkg::TARI_1_NS;
      2'h2:    st_nxt.tari_ns = g2lt_pkg::TARI_2_NS;
      default: st_nxt.tari_ns = g2lt_pkg::TARI_2_NS;
    endcase
    st_nxt.pw_ns  = pw_prod[15:0];
    st_nxt.one_ns = one_prod[15:0];
    st_nxt.crc5   = st_r.tx.crc5;

    // ----------------------------------------
    // Link frequency
    // ----------------------------------------
    // Link frequency; undefined codes report zero kHz
    st_nxt.lf_sel = st_r.rx.link_freq_sel;
    unique case (st_r.rx.link_freq_sel)
      g2lt_pkg::LF_40_SEL:  st_nxt.lf_khz = g2lt_pkg::LF_40_KHZ;
      g2lt_pkg::LF_160_SEL: st_nxt.lf_khz = g2lt_pkg::LF_160_KHZ;
      g2lt_pkg::LF_256_SEL: st_nxt.lf_khz = g2lt_pkg::LF_256_KHZ;
      g2lt_pkg::LF_320_SEL: st_nxt.lf_khz = g2lt_pkg::LF_320_KHZ;
      g2lt_pkg::LF_640_SEL: st_nxt.lf_khz = g2lt_pkg::LF_640_KHZ;
      default:              st_nxt.lf_khz = 10'h000;
    endcase

    // ----------------------------------------
    // Pilot interval
    // ----------------------------------------
    // Pilot interval: 80 shifted down by the shorten field
    st_nxt.pilot = g2lt_pkg::PILOT_BASE >> st_r.rx.pilot_interval_shorten;

    // ----------------------------------------
    // Preamble
    // ----------------------------------------
    // Short preamble only with Miller 4 or 8, else the long one is used
    st_nxt.long_pre = st_r.rx.long_preamble
                      || !((rx_cod_i == g2lt_pkg::COD_M4)
                           || (rx_cod_i == g2lt_pkg::COD_M8));

    // ----------------------------------------
    // Calibration count and analog controls
    // ----------------------------------------
    st_nxt.cal_steps = {st_r.hi.cal_high, st_r.cal_low};
    st_nxt.gain_inc  = st_r.hi.gain_increase;
    st_nxt.mix_low   = st_r.hi.mix_low_supply;
    st_nxt.io_low    = st_r.hi.io_low_voltage;

    // ----------------------------------------
    // Pads
    // ----------------------------------------
    // Open drain pulls low only; a one releases the pad
    if (st_r.hi.open_drain_outputs)
    begin
      st_nxt.pin_out = '0;
      st_nxt.pin_oe  = ~pin_data_i;
    end
    else
    begin
      st_nxt.pin_out = pin_data_i;
      st_nxt.pin_oe  = '1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      st_r           <= '0;
      st_r.tx        <= g2lt_pkg::RST_TX_SHAPE;
      st_r.rx        <= g2lt_pkg::RST_RX_LINK;
      st_r.cal_low   <= g2lt_pkg::RST_CAL_LOW;
      st_r.hi        <= g2lt_pkg::RST_CAL_HIGH;
      st_r.tari_ns   <= g2lt_pkg::TARI_0_NS;
      st_r.long_pre  <= 1'b1;
      st_r.pilot     <= g2lt_pkg::PILOT_BASE;
      st_r.cal_steps <= {g2lt_pkg::RST_CAL_HIGH[3:0], g2lt_pkg::RST_CAL_LOW};
      st_r.pin_oe    <= '1;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o           = st_r.rdata;
  assign rvalid_o          = st_r.rvalid;
  assign cal_insert_o      = st_r.cal_insert;
  assign session_o         = st_r.session;
  assign pulse_width_ns_o  = st_r.pw_ns;
  assign data1_length_ns_o = st_r.one_ns;
  assign crc5_o            = st_r.crc5;
  assign link_freq_sel_o   = st_r.lf_sel;
  assign link_freq_khz_o   = st_r.lf_khz;
  assign pilot_periods_o   = st_r.pilot;
  assign long_preamble_o   = st_r.long_pre;
  assign cal_steps_o       = st_r.cal_steps;
  assign gain_increase_o   = st_r.gain_inc;
  assign mix_low_supply_o  = st_r.mix_low;
  assign io_low_drive_o    = st_r.io_low;
  assign pin_out_o         = st_r.pin_out;
  assign pin_oe_o          = st_r.pin_oe;

endmodule

/* sim/g2lt_host.sv */
// Purpose: Host model for the register port
// Assumes: Strobes change 10 ns after the rising edge
// Notes:   Each task leaves one idle edge so strobes never toggle twice at once
`timescale 1ns/100ps
module g2lt_host
(
  // Clock
  input  wire logic       sys_clk_i,
  // Register port
  output logic            wr_o,
  output logic            rd_o,
  output logic [4:0]      addr_o,
  output logic [7:0]      wdata_o,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i
);
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge sys_clk_i);
    #10;
    wr_o = 1'b0;
    wdata_o = ~d;
    @(posedge sys_clk_i);
    #10;
  endtask
  // Bounded wait: ok stays low if no answer comes
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic ok);
    rd_o = 1'b1;
    addr_o = a;
    ok = 1'b0;
    d = 8'h00;
    @(posedge sys_clk_i);
    #10;
    rd_o = 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      ok = (rvalid_i === 1'b1);
      d = rdata_i;
      @(posedge sys_clk_i);
      #10;
    end
  endtask
endmodule

/* sim/g2lt_regs_monitor.sv */
// Purpose: Port-level assertions for the link timing registers
// Assumes: Writes count only after chip enable has been high five edges
// Notes:   Field checks land two edges after the write edge
`timescale 1ns/100ps
module g2lt_regs_monitor
#(
  parameter int ADDR_W = 5
)
(
  input wire logic              sys_clk_i,
  input wire logic              nrst_i,
  input wire logic              chip_en_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [7:0]        wdata_i,
  input wire logic              rvalid_o,
  input wire logic [1:0]        rx_cod_i,
  input wire logic              cmd_valid_i,
  input wire logic [7:0]        cmd_code_i,
  input wire logic              cal_insert_o,
  input wire logic [1:0]        session_o,
  input wire logic [3:0]        link_freq_sel_o,
  input wire logic [6:0]        pilot_periods_o,
  input wire logic              long_preamble_o,
  input wire logic [11:0]       cal_steps_o
);
  logic [2:0] en_cnt_r;
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i || !chip_en_i)
      en_cnt_r <= 3'h0;
    else if (en_cnt_r != 3'h7)
      en_cnt_r <= en_cnt_r + 3'h1;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_wr_ok(a);
    wr_i && addr_i == a && en_cnt_r > 3'h4;
  endsequence
  a_read_answer: assert property (rd_i |=> rvalid_o) else $error("no read answer");
  a_read_quiet: assert property (!rd_i |=> !rvalid_o) else $error("stray rvalid");
  a_query_cal: assert property (cmd_valid_i && cmd_code_i == g2lt_pkg::CMD_QUERY
    |=> cal_insert_o) else $error("query without calibration");
  a_cmd_other: assert property (!cmd_valid_i
    || !(cmd_code_i inside {8'h98, 8'h90, 8'h91}) |=> !cal_insert_o)
    else $error("stray calibration");
  a_cal_low: assert property (s_wr_ok(g2lt_pkg::ADR_CAL_LOW) |-> ##2
    cal_steps_o[7:0] == $past(wdata_i, 2)) else $error("calibration low wrong");
  a_cal_high: assert property (s_wr_ok(g2lt_pkg::ADR_CAL_HIGH) |-> ##2
    {4'h0, cal_steps_o[11:8]} == ($past(wdata_i, 2) & 8'h0f)) else $error("cal high wrong");
  a_session_bits: assert property (s_wr_ok(g2lt_pkg::ADR_TX_SHAPE) |-> ##2
    {6'h00, session_o} == ($past(wdata_i, 2) & 8'h03)) else $error("session wrong");
  a_rx_decode: assert property (s_wr_ok(g2lt_pkg::ADR_RX_LINK) |-> ##2
    {link_freq_sel_o, 4'h0} == ($past(wdata_i, 2) & 8'hf0) &&
    pilot_periods_o == (7'h50 >> (($past(wdata_i, 2) >> 2) & 8'h03)))
    else $error("rx decode wrong");
  a_preamble_long: assert property (s_wr_ok(g2lt_pkg::ADR_RX_LINK) ##1
    (rx_cod_i != g2lt_pkg::COD_M4 && rx_cod_i != g2lt_pkg::COD_M8) |=> long_preamble_o)
    else $error("short preamble accepted");
  a_reset_preset: assert property ($rose(nrst_i) |->
    cal_steps_o == 12'h535 && pilot_periods_o == 7'h50) else $error("preset wrong");
endmodule
bind g2lt_regs g2lt_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.sys_clk_i(sys_clk_i),
  .nrst_i(nrst_i), .chip_en_i(chip_en_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .rvalid_o(rvalid_o), .rx_cod_i(rx_cod_i), .cmd_valid_i(cmd_valid_i),
  .cmd_code_i(cmd_code_i), .cal_insert_o(cal_insert_o), .session_o(session_o),
  .link_freq_sel_o(link_freq_sel_o), .pilot_periods_o(pilot_periods_o),
  .long_preamble_o(long_preamble_o), .cal_steps_o(cal_steps_o));

/* sim/g2lt_regs_test.sv */
// Purpose: Self-checking bench for the link timing registers
// Assumes: Inputs change 10 ns after the rising edge
// Notes:   Tari code 11 is expected to behave as the 25 us unit
`timescale 1ns/100ps
module g2lt_regs_test;
  logic clk = 1'b0, nrst = 1'b0, chip_en = 1'b1, cmd_valid = 1'b0, wr, rd, rvalid, cal_ins;
  logic [1:0] tari_sel = 2'h0, rx_cod = 2'h2, session;
  logic [7:0] cmd_code = 8'h00, wdata, rdata;
  logic [4:0] addr;
  logic [15:0] pw, d1;
  logic [3:0] lfsel;
  logic [9:0] lfkhz;
  logic [6:0] pilot;
  logic [11:0] cal_steps;
  logic crc5, lpre, gain, mix, iol;
  g2lt_pkg::g2lt_pin3_t pin_data = 3'h0, pin_out, pin_oe;
  logic [7:0] pwf [4] = '{8'h1b, 8'h23, 8'h2c, 8'h32};
  logic [7:0] onef [4] = '{8'h96, 8'ha6, 8'hb7, 8'hc8};
  logic [7:0] cmds [4] = '{8'h98, 8'h90, 8'h91, 8'h5a};
  logic [3:0] lfc [5] = '{4'h0, 4'h6, 4'h9, 4'hc, 4'hf};
  int errors = 0, checked = 0;
  always #50 clk = ~clk;
  g2lt_host host (.sys_clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
    .rdata_i(rdata), .rvalid_i(rvalid));
  g2lt_regs uut (.sys_clk_i(clk), .nrst_i(nrst), .chip_en_i(chip_en), .wr_i(wr), .rd_i(rd),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .tari_sel_i(tari_sel),
    .rx_cod_i(rx_cod), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cal_insert_o(cal_ins),
    .session_o(session), .pulse_width_ns_o(pw), .data1_length_ns_o(d1), .crc5_o(crc5),
    .link_freq_sel_o(lfsel), .link_freq_khz_o(lfkhz), .pilot_periods_o(pilot),
    .long_preamble_o(lpre), .cal_steps_o(cal_steps), .gain_increase_o(gain),
    .mix_low_supply_o(mix), .io_low_drive_o(iol), .pin_data_i(pin_data), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe));
  task automatic stop_test;
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %0t: output %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    checked++;
    if (!ok || d !== exp)
    begin
      errors++;
      $display("Error %0t: reg %h read %h expected %h", $time, a, d, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk_presets;
    chk_reg(g2lt_pkg::ADR_TX_SHAPE, 8'hf0);
    chk_reg(g2lt_pkg::ADR_RX_LINK, 8'h60);
    chk_reg(g2lt_pkg::ADR_CAL_LOW, 8'h35);
    chk_reg(g2lt_pkg::ADR_CAL_HIGH, 8'h05);
  endtask
  function automatic logic [15:0] t_ns(input logic [1:0] t, input logic [7:0] f);
    logic [31:0] u;
    u = (t == 2'h0) ? 32'h186a : (t == 2'h1) ? 32'h30d4 : 32'h61a8;
    return 16'((u * f) / 32'h64);
  endfunction
  function automatic logic [9:0] lf_khz(input logic [3:0] c);
    case (c)
      4'h0: return 10'h028;
      4'h6: return 10'h0a0;
      4'h9: return 10'h100;
      4'hc: return 10'h140;
      4'hf: return 10'h280;
      default: return 10'h000;
    endcase
  endfunction
  initial
  begin
    int i;
    logic [7:0] d, e;
    i = $urandom(4);
    cyc(20);
    nrst = 1'b1;
    cyc(6);
    chk_presets();
    for (i = 0; i < 12; i++)
    begin
      e = (i == 11) ? 8'h1b : 8'h02 + 8'($urandom_range(3));
      d = 8'($urandom);
      host.wr(e[4:0], d);
      chk_reg(e[4:0], (i == 11) ? 8'h00 : d);
    end
    // Every pulse code against each Tari unit; each data-1 and command code with one Tari unit
    for (i = 0; i < 16; i++)
    begin
      d = {4'(i), 1'($urandom), i[2], 2'($urandom)};
      tari_sel = 2'(i % 4);
      host.wr(g2lt_pkg::ADR_TX_SHAPE, d);
      cyc(4);
      chk_out(pw, t_ns(tari_sel, pwf[d[7:6]]));
      chk_out(d1, t_ns(tari_sel, onef[d[5:4]]));
      chk_out(16'(session), 16'(d[1:0]));
      chk_out(16'(crc5), 16'(d[3]));
      cmd_valid = 1'b1;
      cmd_code = cmds[i[1:0]];
      cyc(1);
      cmd_valid = 1'b0;
      chk_out(16'(cal_ins), 16'(i[1:0] == 2'h0 || (i[1:0] != 2'h3 && d[2])));
    end
    for (i = 0; i < 20; i++)
    begin
      // Last pass uses an unassigned link code
      d = {(i == 19) ? 4'h3 : lfc[i % 5], 2'(i / 5), 1'($urandom), 1'b0};
      rx_cod = 2'(i);
      host.wr(g2lt_pkg::ADR_RX_LINK, d);
      cyc(3);
      chk_out(16'(lfkhz), 16'(lf_khz(d[7:4])));
      chk_out(16'(lfsel), 16'(d[7:4]));
      chk_out(16'(pilot), 16'(7'h50 >> d[3:2]));
      chk_out(16'(lpre), 16'(d[1] | (rx_cod < g2lt_pkg::COD_M4)));
    end
    // Open-drain bit is set on odd passes; the other high-register bits are random
    for (i = 0; i < 8; i++)
    begin
      d = 8'($urandom);
      e = {3'($urandom), i[0], 4'($urandom)};
      host.wr(g2lt_pkg::ADR_CAL_LOW, d);
      host.wr(g2lt_pkg::ADR_CAL_HIGH, e);
      pin_data = 3'($urandom);
      cyc(3);
      chk_out(16'(cal_steps), 16'({e[3:0], d}));
      chk_out(16'({gain, mix, iol}), 16'(e[7:5]));
      chk_out(16'(pin_oe), e[4] ? {13'h0000, ~pin_data} : 16'h0007);
      chk_out(16'(pin_out), e[4] ? 16'h0000 : 16'(pin_data));
    end
    // Chip enable low restores presets and drops writes
    chip_en = 1'b0;
    cyc(5);
    host.wr(g2lt_pkg::ADR_CAL_LOW, 8'h00);
    chk_presets();
    chip_en = 1'b1;
    cyc(5);
    host.wr(g2lt_pkg::ADR_CAL_LOW, 8'h99);
    chk_reg(g2lt_pkg::ADR_CAL_LOW, 8'h99);
    nrst = 1'b0;
    cyc(3);
    nrst = 1'b1;
    cyc(3);
    chk_presets();
    stop_test();
  end
  initial
  begin
    #4000000;
    errors++;
    stop_test();
  end
endmodule
